// >>> hw/ipctl_cfg.svh
// Register map, field positions and reset values of the pipe and scaler control block
// Functional notes
// - Run-enable bit starts frame processing
// - One-shot mode processes one frame, stops
// - Run-enable clear latched at frame end
// - Five pipe and five scaler events
// - Event enabling lives outside; pulses feed DMA
// - Pipe event zero at update-permitted point
// - Pipe event one at final pixel
// - Pipe event two at DMA done, end-of-frame
// - Pipe event three at boundary calc done
// - Pipe event four at histogram done
// - Update at area start, last pixel at end
// - Scaler update event at update-permitted point
// - Scaler last-pixel event at final pixel
// - Scaler DMA done after both outputs written
// - Per-output line event every N lines
// - Clock-select bit makes interface drive pixel clock
// - Histogram auto-clear makes memory self-cleaning
// - Alpha used only for color type zero
// - Shadow writes apply at next frame start
// - Busy-writeable registers change immediately
`ifndef IPCTL_CFG_SVH
`define IPCTL_CFG_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define IPCTL_OFS_RUN 8'h00
`define IPCTL_OFS_MODE 8'h04
`define IPCTL_OFS_STATUS 8'h08
`define IPCTL_OFS_AINT 8'h0C
`define IPCTL_OFS_BINT 8'h10
`define IPCTL_OFS_SCFG 8'h14
`define IPCTL_OFS_AHSTEP 8'h18
`define IPCTL_OFS_AVSTEP 8'h1C
`define IPCTL_OFS_CLK 8'h20

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define IPCTL_MODE_ONESHOT 0
`define IPCTL_MODE_PFMT 1
`define IPCTL_SCFG_AEN 0
`define IPCTL_SCFG_BEN 1
`define IPCTL_SCFG_A420 2
`define IPCTL_SCFG_ADWN 3
`define IPCTL_SCFG_ARGB 4
`define IPCTL_SCFG_RGBTYP 5
`define IPCTL_SCFG_SFMT 6
`define IPCTL_SCFG_ALPHA 8
`define IPCTL_CLK_GATE 0
`define IPCTL_CLK_SEL 1
`define IPCTL_CLK_HCLR 2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define IPCTL_RST_STEP 10'h100
`define IPCTL_RST_INT 13'h0000

`endif

// >>> hw/ipctl_pkg.sv
// Types shared by the pipe and scaler control block
package ipctl_pkg;
   // Frame state, Gray-coded along idle -> wait -> active -> drain
   typedef enum logic [1:0]
   {
      IPCTL_IDLE = 2'b00,
      IPCTL_WAIT = 2'b01,
      IPCTL_ACTIVE = 2'b11,
      IPCTL_DRAIN = 2'b10
   } ipctl_state_t;
endpackage : ipctl_pkg

// >>> hw/ipctl_top.sv
// Frame control, event pulses and register file of the pipe and scaler
`timescale 1ns/100ps
`include "ipctl_cfg.svh"

module ipctl_top
#(
   parameter int LINE_W = 13
)
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hsel,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic frameStart,
   input wire logic lastPixelIn,
   input wire logic pipeDmaDone,
   input wire logic boundaryCalcDone,
   input wire logic histogramDone,
   input wire logic scalerStart,
   input wire logic scalerLastPixelIn,
   input wire logic scalerADmaDone,
   input wire logic scalerBDmaDone,
   input wire logic scalerALineWritten,
   input wire logic scalerBLineWritten,
   output logic pipeBusy,
   output logic pipe_event_0,
   output logic pipe_event_1,
   output logic pipe_event_2,
   output logic pipe_event_3,
   output logic pipe_event_4,
   output logic pipe_end_of_frame,
   output logic scaler_update_event,
   output logic scaler_last_pixel_event,
   output logic scaler_dma_done_event,
   output logic scaler_a_line_event,
   output logic scaler_b_line_event,
   output logic scaler_end_of_frame,
   output logic scaler_a_enable,
   output logic scaler_b_enable,
   output logic scaler_a_chroma_subsample,
   output logic scaler_a_downscale_enable,
   output logic scaler_a_color_out_enable,
   output logic scaler_color_out_type,
   output logic [1:0] scaler_source_format,
   output logic pipe_source_format,
   output logic [9:0] scaler_a_horizontal_step,
   output logic [9:0] scaler_a_vertical_step,
   output logic [7:0] alphaOut,
   output logic alphaValid,
   output logic register_clock_gate,
   output logic pixel_clock_select,
   output logic histogram_auto_clear,
   output logic histogramClearReq
);
   import ipctl_pkg::*;

   // ----------------------------------------------------------------------------
   // Bus address phase capture
   // ----------------------------------------------------------------------------
   logic wrPend_q;
   logic [7:0] wrAddr_q;
   logic addrOk;

   // Single-cycle decode of the transfer offered this cycle
   assign addrOk = hsel && hready && htrans[1];

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         wrPend_q <= 1'b0;
         wrAddr_q <= 8'h00;
      end
      else
      begin
         wrPend_q <= addrOk && hwrite;
         wrAddr_q <= haddr[7:0];
      end
   end

   // Slave always ready, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // ----------------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------------
   logic runEn_q;
   logic oneShot_q;
   logic pfmt_q;
   logic [LINE_W-1:0] aInt_q;
   logic [LINE_W-1:0] bInt_q;
   logic [15:0] scfgSh_q;
   logic [15:0] scfg_q;
   logic [9:0] ahStepSh_q;
   logic [9:0] avStepSh_q;
   logic [9:0] ahStep_q;
   logic [9:0] avStep_q;
   logic [2:0] clk_q;
   logic runWr;
   logic runClr;
   ipctl_state_t state_q;

   function automatic logic isWr(input logic [7:0] ofs);
      isWr = wrPend_q && (wrAddr_q == ofs);
   endfunction : isWr

   assign runWr = isWr(`IPCTL_OFS_RUN);

   // Busy-writeable controls take effect at once
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         oneShot_q <= 1'b0;
         pfmt_q <= 1'b0;
         aInt_q <= LINE_W'(`IPCTL_RST_INT);
         bInt_q <= LINE_W'(`IPCTL_RST_INT);
         clk_q <= 3'h0;
      end
      else
      begin
         if (isWr(`IPCTL_OFS_MODE))
         begin
            oneShot_q <= hwdata[`IPCTL_MODE_ONESHOT];
            pfmt_q <= hwdata[`IPCTL_MODE_PFMT];
         end
         if (isWr(`IPCTL_OFS_AINT))
            aInt_q <= hwdata[LINE_W-1:0];
         if (isWr(`IPCTL_OFS_BINT))
            bInt_q <= hwdata[LINE_W-1:0];
         if (isWr(`IPCTL_OFS_CLK))
            clk_q <= hwdata[2:0];
      end
   end

   // Shadow copies read back the last write
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         scfgSh_q <= 16'h0000;
         ahStepSh_q <= `IPCTL_RST_STEP;
         avStepSh_q <= `IPCTL_RST_STEP;
      end
      else
      begin
         if (isWr(`IPCTL_OFS_SCFG))
            scfgSh_q <= hwdata[15:0];
         if (isWr(`IPCTL_OFS_AHSTEP))
            ahStepSh_q <= hwdata[9:0];
         if (isWr(`IPCTL_OFS_AVSTEP))
            avStepSh_q <= hwdata[9:0];
      end
   end

   // Working settings load only at frame start
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         scfg_q <= 16'h0000;
         ahStep_q <= `IPCTL_RST_STEP;
         avStep_q <= `IPCTL_RST_STEP;
      end
      else if (frameStart && state_q == IPCTL_WAIT && runEn_q)
      begin
         scfg_q <= scfgSh_q;
         ahStep_q <= ahStepSh_q;
         avStep_q <= avStepSh_q;
      end
   end

   // Run enable: set by software, cleared at the last pixel of a one-shot frame
   assign runClr = lastPixelIn && state_q == IPCTL_ACTIVE && oneShot_q;
   always_ff @(posedge mclk)
   begin
      if (rst)
         runEn_q <= 1'b0;
      else if (runWr)
         runEn_q <= hwdata[0];
      else if (runClr)
         runEn_q <= 1'b0;
   end

   // ----------------------------------------------------------------------------
   // Frame state machine
   // ----------------------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (rst)
         state_q <= IPCTL_IDLE;
      else
      begin
         case (state_q)
            IPCTL_IDLE:
               if (runEn_q)
                  state_q <= IPCTL_WAIT;
            IPCTL_WAIT:
               if (!runEn_q)
                  state_q <= IPCTL_IDLE;
               else if (frameStart)
                  state_q <= IPCTL_ACTIVE;
            IPCTL_ACTIVE:
               if (lastPixelIn)
                  state_q <= IPCTL_DRAIN;
            IPCTL_DRAIN:
               // Disable is sampled only at frame end
               if (pipeDmaDone)
                  state_q <= runEn_q ? IPCTL_WAIT : IPCTL_IDLE;
            default:
               state_q <= IPCTL_IDLE;
         endcase
      end
   end

   assign pipeBusy = (state_q == IPCTL_ACTIVE) || (state_q == IPCTL_DRAIN);

   // ----------------------------------------------------------------------------
   // Event pulses
   // ----------------------------------------------------------------------------
   logic aDone_q;
   logic bDone_q;
   logic sActive_q;
   logic [LINE_W-1:0] aCnt_q;
   logic [LINE_W-1:0] bCnt_q;
   logic bothDone;
   logic aHit;
   logic bHit;

   // Line counter reaching its interval, zero interval disables
   function automatic logic lineHit(input logic [LINE_W-1:0] cnt,
                                    input logic [LINE_W-1:0] n, input logic inc);
      lineHit = inc && (n != '0) && (cnt == n - LINE_W'(1));
   endfunction : lineHit

   assign aHit = lineHit(aCnt_q, aInt_q, scalerALineWritten);
   assign bHit = lineHit(bCnt_q, bInt_q, scalerBLineWritten);
   assign bothDone = (aDone_q || scalerADmaDone) && (bDone_q || scalerBDmaDone)
                     && sActive_q;

   // Scaler frame tracking and per-output line counters
   always_ff @(posedge mclk)
   begin
      if (rst || scalerStart)
      begin
         aDone_q <= 1'b0;
         bDone_q <= 1'b0;
         aCnt_q <= '0;
         bCnt_q <= '0;
         sActive_q <= scalerStart && !rst;
      end
      else
      begin
         aDone_q <= bothDone ? 1'b0 : (aDone_q || scalerADmaDone);
         bDone_q <= bothDone ? 1'b0 : (bDone_q || scalerBDmaDone);
         if (bothDone)
            sActive_q <= 1'b0;
         if (scalerALineWritten)
            aCnt_q <= aHit ? '0 : aCnt_q + LINE_W'(1);
         if (scalerBLineWritten)
            bCnt_q <= bHit ? '0 : bCnt_q + LINE_W'(1);
      end
   end

   // One-cycle registered event pulses; gating lies outside
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         pipe_event_0 <= 1'b0;
         pipe_event_1 <= 1'b0;
         pipe_event_2 <= 1'b0;
         pipe_event_3 <= 1'b0;
         pipe_event_4 <= 1'b0;
         pipe_end_of_frame <= 1'b0;
         scaler_update_event <= 1'b0;
         scaler_last_pixel_event <= 1'b0;
         scaler_dma_done_event <= 1'b0;
         scaler_end_of_frame <= 1'b0;
         scaler_a_line_event <= 1'b0;
         scaler_b_line_event <= 1'b0;
      end
      else
      begin
         pipe_event_0 <= frameStart && state_q == IPCTL_WAIT && runEn_q;
         pipe_event_1 <= lastPixelIn && state_q == IPCTL_ACTIVE;
         pipe_event_2 <= pipeDmaDone && state_q == IPCTL_DRAIN;
         pipe_end_of_frame <= pipeDmaDone && state_q == IPCTL_DRAIN;
         pipe_event_3 <= boundaryCalcDone && pipeBusy;
         pipe_event_4 <= histogramDone && pipeBusy;
         scaler_update_event <= scalerStart;
         scaler_last_pixel_event <= scalerLastPixelIn && sActive_q;
         scaler_dma_done_event <= bothDone;
         scaler_end_of_frame <= bothDone;
         scaler_a_line_event <= aHit && sActive_q;
         scaler_b_line_event <= bHit && sActive_q;
      end
   end

   // ----------------------------------------------------------------------------
   // Settings to the datapath
   // ----------------------------------------------------------------------------
   assign scaler_a_enable = scfg_q[`IPCTL_SCFG_AEN];
   assign scaler_b_enable = scfg_q[`IPCTL_SCFG_BEN];
   assign scaler_a_chroma_subsample = scfg_q[`IPCTL_SCFG_A420];
   assign scaler_a_downscale_enable = scfg_q[`IPCTL_SCFG_ADWN];
   assign scaler_a_color_out_enable = scfg_q[`IPCTL_SCFG_ARGB];
   assign scaler_color_out_type = scfg_q[`IPCTL_SCFG_RGBTYP];
   assign scaler_source_format = scfg_q[`IPCTL_SCFG_SFMT+1:`IPCTL_SCFG_SFMT];
   assign pipe_source_format = pfmt_q;
   assign scaler_a_horizontal_step = ahStep_q;
   assign scaler_a_vertical_step = avStep_q;
   // Alpha is applied only for enabled 32-bit color output
   assign alphaValid = scfg_q[`IPCTL_SCFG_ARGB] && !scfg_q[`IPCTL_SCFG_RGBTYP];
   assign alphaOut = alphaValid ? scfg_q[`IPCTL_SCFG_ALPHA+7:`IPCTL_SCFG_ALPHA] : 8'h00;
   assign register_clock_gate = clk_q[`IPCTL_CLK_GATE];
   assign pixel_clock_select = clk_q[`IPCTL_CLK_SEL];
   assign histogram_auto_clear = clk_q[`IPCTL_CLK_HCLR];
   // Self-clearing histogram after each completed collection
   assign histogramClearReq = histogram_auto_clear && pipe_event_4;

   // ----------------------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------------------
   logic rdPend_q;
   logic [7:0] rdAddr_q;

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         rdPend_q <= 1'b0;
         rdAddr_q <= 8'h00;
      end
      else
      begin
         rdPend_q <= addrOk && !hwrite;
         rdAddr_q <= haddr[7:0];
      end
   end

   // Data phase mux; unmapped offsets read zero
   always_comb
   begin
      hrdata = 32'h0000_0000;
      if (!rdPend_q)
         hrdata = 32'h0000_0000;
      else if (rdAddr_q == `IPCTL_OFS_RUN)
         hrdata = {31'h0, runEn_q};
      else if (rdAddr_q == `IPCTL_OFS_MODE)
         hrdata = {30'h0, pfmt_q, oneShot_q};
      else if (rdAddr_q == `IPCTL_OFS_STATUS)
         hrdata = {29'h0, sActive_q, state_q};
      else if (rdAddr_q == `IPCTL_OFS_AINT)
         hrdata = 32'(aInt_q);
      else if (rdAddr_q == `IPCTL_OFS_BINT)
         hrdata = 32'(bInt_q);
      else if (rdAddr_q == `IPCTL_OFS_SCFG)
         hrdata = {16'h0, scfgSh_q};
      else if (rdAddr_q == `IPCTL_OFS_AHSTEP)
         hrdata = {22'h0, ahStepSh_q};
      else if (rdAddr_q == `IPCTL_OFS_AVSTEP)
         hrdata = {22'h0, avStepSh_q};
      else if (rdAddr_q == `IPCTL_OFS_CLK)
         hrdata = {29'h0, clk_q};
   end
endmodule : ipctl_top

// >>> testbench/ipctl_chk.sv
// Checker of frame control and event pulse timing at the block's ports
`timescale 1ns/100ps
module ipctl_chk
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic frameStart,
   input wire logic lastPixelIn,
   input wire logic pipeDmaDone,
   input wire logic boundaryCalcDone,
   input wire logic histogramDone,
   input wire logic scalerStart,
   input wire logic scalerADmaDone,
   input wire logic scalerBDmaDone,
   input wire logic pipeBusy,
   input wire logic pipe_event_0,
   input wire logic pipe_event_1,
   input wire logic pipe_event_2,
   input wire logic pipe_event_3,
   input wire logic pipe_event_4,
   input wire logic pipe_end_of_frame,
   input wire logic scaler_update_event,
   input wire logic scaler_dma_done_event,
   input wire logic scaler_end_of_frame,
   input wire logic scaler_a_color_out_enable,
   input wire logic scaler_color_out_type,
   input wire logic alphaValid,
   input wire logic histogram_auto_clear,
   input wire logic histogramClearReq
);
   // ---------------------------------------------------------------
   // Event timing, one cycle after the cause
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   chk_update_start: assert property (pipe_event_0 |-> $past(frameStart) && pipeBusy)
      else $error("pipe update event without frame start");
   chk_busy_rise: assert property ($rose(pipeBusy) |-> pipe_event_0)
      else $error("pipe started without update event");
   chk_last_pixel: assert property (pipe_event_1 |-> $past(lastPixelIn) && $past(pipeBusy))
      else $error("last pixel event without cause");
   chk_dma_eof: assert property (pipe_event_2 |-> $past(pipeDmaDone) && pipe_end_of_frame)
      else $error("pipe dma event without end of frame");
   chk_boundary_done: assert property (pipe_event_3 |-> $past(boundaryCalcDone))
      else $error("boundary event without cause");
   chk_hist_done: assert property (pipe_event_4 |-> $past(histogramDone))
      else $error("histogram event without cause");
   chk_hist_clear: assert property (histogramClearReq ==
      (histogram_auto_clear && $past(histogramDone && pipeBusy)))
      else $error("histogram clear request mismatch");
   chk_scaler_dma: assert property (scaler_dma_done_event |-> scaler_end_of_frame
      && $past(scalerADmaDone || scalerBDmaDone)) else $error("scaler dma event without cause");
   chk_scaler_update: assert property (scaler_update_event |-> $past(scalerStart))
      else $error("scaler update event without start");
   chk_pulse_width: assert property (pipe_event_0 |=> !pipe_event_0)
      else $error("update event longer than one cycle");
   chk_frame_end: assert property ($fell(pipeBusy) |-> pipe_event_2)
      else $error("pipe stopped before frame end");
   chk_alpha_gate: assert property (alphaValid |-> scaler_a_color_out_enable && !scaler_color_out_type)
      else $error("alpha valid outside 32-bit colour mode");

   // Main scenarios reached
   cov_frame_end: cover property (pipe_event_2 && pipe_end_of_frame);
   cov_scaler_done: cover property (scaler_dma_done_event);
   cov_alpha: cover property (alphaValid);
endmodule : ipctl_chk

// >>> testbench/ipctl_frame_src.sv
// Upstream frame source: ordered frame, line and done pulses
`timescale 1ns/100ps
module ipctl_frame_src
(
   input wire logic mclk,
   output logic frameStart,
   output logic lastPixelIn,
   output logic pipeDmaDone,
   output logic boundaryCalcDone,
   output logic histogramDone,
   output logic scalerStart,
   output logic scalerLastPixelIn,
   output logic scalerADmaDone,
   output logic scalerBDmaDone,
   output logic scalerALineWritten,
   output logic scalerBLineWritten
);
   logic [10:0] pls = 11'h000;

   // Pulse vector onto the pins, driven on mclk edges by the pulse task
   assign {scalerBLineWritten, scalerALineWritten, scalerBDmaDone, scalerADmaDone,
      scalerLastPixelIn, scalerStart, histogramDone, boundaryCalcDone, pipeDmaDone,
      lastPixelIn, frameStart} = pls;

   task pulse(input logic [10:0] v, input int gap);
      @(posedge mclk);
      pls <= v;
      @(posedge mclk);
      pls <= 11'h000;
      repeat (gap) @(posedge mclk);
   endtask : pulse

   // One frame in order; gap stretches every step for a slow source
   task run_frame(input int lines, input int gap);
      pulse(11'h001, gap);
      pulse(11'h020, gap);
      repeat (lines) pulse(11'h600, gap);
      pulse(11'h002, gap);
      pulse(11'h040, gap);
      pulse(11'h018, gap);
      pulse(11'h004, gap);
      if (gap == 0)
         pulse(11'h180, 0);
      else
      begin
         pulse(11'h080, gap);
         pulse(11'h100, gap);
      end
      repeat (3) @(posedge mclk);
   endtask : run_frame
endmodule : ipctl_frame_src

// >>> testbench/tb_top.sv
// Testbench: bus tasks, frame scenarios and event count checks
`timescale 1ns/100ps
`include "ipctl_cfg.svh"
module tb_top;
   // ---------------------------------------------------------------
   // Signals, design and partner
   // ---------------------------------------------------------------
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [31:0] haddr = 32'h00000000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h00000000;
   logic hsel = 1'b1;
   logic hready;
   logic [31:0] hrdata;
   logic hreadyout, hresp, pipeBusy, pipe_end_of_frame, alphaValid, histogramClearReq;
   logic frameStart, lastPixelIn, pipeDmaDone, boundaryCalcDone, histogramDone, scalerStart;
   logic scalerLastPixelIn, scalerADmaDone, scalerBDmaDone, scalerALineWritten, scalerBLineWritten;
   logic pipe_event_0, pipe_event_1, pipe_event_2, pipe_event_3, pipe_event_4;
   logic scaler_update_event, scaler_last_pixel_event, scaler_dma_done_event;
   logic scaler_a_line_event, scaler_b_line_event, scaler_end_of_frame;
   logic scaler_a_enable, scaler_b_enable, scaler_a_chroma_subsample, scaler_a_downscale_enable;
   logic scaler_a_color_out_enable, scaler_color_out_type, pipe_source_format;
   logic [1:0] scaler_source_format;
   logic [9:0] scaler_a_horizontal_step, scaler_a_vertical_step;
   logic [7:0] alphaOut;
   logic register_clock_gate, pixel_clock_select, histogram_auto_clear;
   logic [12:0] evs;
   logic [31:0] rdv;
   int cnt [13];
   int fail_count = 0;
   int total_checks = 0;
   int cycles = 0;

   assign hready = hreadyout;
   assign evs = {histogramClearReq, scaler_b_line_event, scaler_a_line_event,
      scaler_end_of_frame, scaler_dma_done_event, scaler_last_pixel_event, scaler_update_event,
      pipe_end_of_frame, pipe_event_4, pipe_event_3, pipe_event_2, pipe_event_1, pipe_event_0};

   ipctl_top dut (.*);
   ipctl_frame_src src (.*);

   always #50 mclk = ~mclk;

   // Event pulse counters and the hang limit
   always @(posedge mclk)
   begin
      cycles <= cycles + 1;
      for (int i = 0; i < 13; i++)
         if (evs[i] === 1'b1)
            cnt[i] <= cnt[i] + 1;
      if (cycles == 20000)
      begin
         fail_count = fail_count + 1;
         finish_test();
      end
   end

   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // One AHB-Lite single word transfer; read data taken at the data phase edge
   task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      haddr <= {24'h000000, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      rdv = hrdata;
      chk("response", 32'h00000000, {31'h0, hresp});
   endtask : ahb

   task rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
      ahb(1'b0, a, 32'h00000000);
      chk(name, exp, rdv);
   endtask : rd_chk

   // Line events at index 10 and 11, all others once per frame
   task chk_frames(input int n, input int la, input int lb);
      for (int i = 0; i < 13; i++)
         chk($sformatf("event count %0d", i), (i == 10) ? la : (i == 11) ? lb : n, cnt[i]);
   endtask : chk_frames

   task finish_test;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : finish_test

   initial
   begin
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      rd_chk("mode", `IPCTL_OFS_MODE, 32'h00000000);
      rd_chk("h step", `IPCTL_OFS_AHSTEP, 32'h00000100);
      ahb(1'b1, 8'h40, 32'hFFFFFFFF);
      rd_chk("unmapped", 8'h40, 32'h00000000);
      $display("test reset done");
      // Bypass setup; scfg and steps held in shadow until first frame start, clock and intervals at once
      ahb(1'b1, `IPCTL_OFS_CLK, 32'h00000007);
      ahb(1'b1, `IPCTL_OFS_SCFG, 32'h00000001);
      ahb(1'b1, `IPCTL_OFS_AHSTEP, 32'h00000100);
      ahb(1'b1, `IPCTL_OFS_AVSTEP, 32'h00000100);
      ahb(1'b1, `IPCTL_OFS_AINT, 32'h00000002);
      ahb(1'b1, `IPCTL_OFS_BINT, 32'h00000003);
      @(negedge mclk);
      chk("clock bits", 32'h00000007, {29'h0, histogram_auto_clear, pixel_clock_select,
         register_clock_gate});
      chk("a enable held", 32'h00000000, {31'h0, scaler_a_enable});
      rd_chk("scfg", `IPCTL_OFS_SCFG, 32'h00000001);
      ahb(1'b1, `IPCTL_OFS_RUN, 32'h00000001);
      src.run_frame(6, 0);
      chk_frames(1, 3, 2);
      chk("a enable", 32'h00000001, {31'h0, scaler_a_enable});
      chk("h step", 32'h00000100, {22'h0, scaler_a_horizontal_step});
      chk("v step", 32'h00000100, {22'h0, scaler_a_vertical_step});
      chk("scaler cfg", 32'h00000001, {24'h0, scaler_source_format, scaler_color_out_type,
         scaler_a_color_out_enable, scaler_a_downscale_enable, scaler_a_chroma_subsample,
         scaler_b_enable, scaler_a_enable});
      rd_chk("status wait", `IPCTL_OFS_STATUS, 32'h00000001);
      $display("test bypass done");
      // Slow frame with raw-through and alpha written mid-frame
      fork
         src.run_frame(6, 2);
         begin
            repeat (6) @(posedge mclk);
            ahb(1'b1, `IPCTL_OFS_SCFG, 32'h0000A551);
            ahb(1'b1, `IPCTL_OFS_MODE, 32'h00000002);
            @(negedge mclk);
            chk("pipe fmt", 32'h00000001, {31'h0, pipe_source_format});
            chk("fmt held", 32'h00000000, {30'h0, scaler_source_format});
            rd_chk("scfg new", `IPCTL_OFS_SCFG, 32'h0000A551);
         end
      join
      // Stop written during the last frame
      fork
         src.run_frame(6, 0);
         begin
            repeat (4) @(posedge mclk);
            ahb(1'b1, `IPCTL_OFS_RUN, 32'h00000000);
            @(negedge mclk);
            chk("busy after stop", 32'h00000001, {31'h0, pipeBusy});
         end
      join
      chk_frames(3, 9, 6);
      rd_chk("status idle", `IPCTL_OFS_STATUS, 32'h00000000);
      chk("raw fmt", 32'h00000001, {30'h0, scaler_source_format});
      chk("alpha", 32'h000001A5, {23'h0, alphaValid, alphaOut});
      src.run_frame(2, 0);
      chk("no run", 32'h00000003, cnt[0]);
      $display("test continuous done");
      // One-shot: exactly one frame
      ahb(1'b1, `IPCTL_OFS_MODE, 32'h00000001);
      ahb(1'b1, `IPCTL_OFS_RUN, 32'h00000001);
      src.run_frame(2, 0);
      chk("oneshot frame", 32'h00000004, cnt[2]);
      rd_chk("run cleared", `IPCTL_OFS_RUN, 32'h00000000);
      src.run_frame(2, 0);
      chk("oneshot stop", 32'h00000004, cnt[0]);
      $display("test oneshot done");
      finish_test();
   end
endmodule : tb_top

bind ipctl_top ipctl_chk chk (.*);
